// ===== core/drs_top.sv
// dram clock-change and self-refresh sequencer with its register file
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "drs_defines.svh"
module drs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic memory_clock,
  input wire logic bus_req_valid,
  output logic bus_req_ready,
  output drs_pkg::drs_cmd_t mem_cmd,
  output logic mem_cke,
  output logic mem_reset_n,
  output logic dll_reset,
  output logic clock_src_sel
);
  import drs_pkg::*;

  drs_top_st_t st_reg;
  drs_top_st_t st_next;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [7:0] rd_addr_q;
  logic [31:0] rd_data;
  logic rd_err;
  logic [31:0] wmask;
  logic mclk_s;
  logic rise;
  logic done;
  logic cal_done;
  drs_mode_t mode;
  logic is_ddr3;
  logic [3:0] cl;
  logic [3:0] cwl;
  logic [2:0] al_sel;
  logic [3:0] al;
  logic [3:0] rl;
  logic [3:0] wl;
  logic cfg_err;
  logic freq_err;
  logic [8:0] freq;
  logic idle;
  logic [31:0] stat;

  drs_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // the memory clock is only sampled; its rising edges pace all memory timing
  drs_sync u_mclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(memory_clock),
    .sync_out(mclk_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  assign rd_addr_q = s_axi_araddr;
  assign rise = mclk_s && !st_reg.mprev;
  assign done = (st_reg.cnt == 12'h000);
  assign cal_done = (st_reg.cal_cnt == 12'h000);

  // configuration decode and latency arithmetic
  always_comb begin
    mode = drs_mode_t'(st_reg.ctl[`DRS_CTL_MODE]);
    is_ddr3 = (mode == DRS_DDR3);
    cl = st_reg.ctl[`DRS_CTL_CL];
    cwl = st_reg.ctl[`DRS_CTL_CWL];
    al_sel = st_reg.ctl[`DRS_CTL_AL];
    freq = st_reg.ctl[`DRS_CTL_FREQ];
    cfg_err = (st_reg.ctl[`DRS_CTL_MODE] == 2'h3);
    al = 4'h0;
    if (mode == DRS_DDR2) begin
      if (al_sel <= `DRS_AL_DDR2_MAX) begin
        al = {1'b0, al_sel};
      end else begin
        cfg_err = 1'b1;
      end
    end else if (is_ddr3) begin
      if (al_sel == 3'h1) begin
        al = 4'(cl - 4'h1);
      end else if (al_sel == 3'h2) begin
        al = 4'(cl - 4'h2);
      end else if (al_sel != 3'h0) begin
        cfg_err = 1'b1;
      end
    end else if (al_sel != 3'h0) begin
      cfg_err = 1'b1;
    end
    if (mode == DRS_LPDDR) begin
      rl = cl;
      wl = `DRS_WL_LPDDR;
    end else begin
      rl = 4'(al + cl);
      wl = is_ddr3 ? 4'(al + cwl) : 4'(rl - 4'h1);
    end
    // ceiling 450 MHz, i.e. 900 MT/s; faster ddr3 grades unusable
    freq_err = (freq > `DRS_FREQ_MAX_MHZ);
    if (mode == DRS_DDR2 && freq < `DRS_FREQ_DDR2_MIN) begin
      freq_err = 1'b1;
    end
  end

  // idle means nothing queued and the sequencer in S_RUN
  assign idle = (st_reg.seq == S_RUN) && !bus_req_valid;

  always_comb begin
    stat = '0;
    stat[`DRS_ST_IDLE] = idle;
    stat[`DRS_ST_SRACK] = st_reg.srack;
    stat[`DRS_ST_DLLRST] = st_reg.phy0[`DRS_PHY0_DLLRST];
    stat[`DRS_ST_INITDONE] = st_reg.init_done;
    stat[`DRS_ST_CALBUSY] = st_reg.cal_busy;
    stat[`DRS_ST_CFGERR] = cfg_err;
    stat[`DRS_ST_FREQERR] = freq_err;
    stat[`DRS_ST_CHOP] = is_ddr3 && !st_reg.ctl[`DRS_CTL_BL8];
    stat[`DRS_ST_RL] = rl;
    stat[`DRS_ST_WL] = wl;
  end

  always_comb begin
    rd_err = 1'b0;
    unique case (rd_addr_q)
      `DRS_OFF_CTL: rd_data = st_reg.ctl;
      `DRS_OFF_STAT: rd_data = stat;
      `DRS_OFF_PHY0: rd_data = st_reg.phy0;
      `DRS_OFF_PHY1: rd_data = st_reg.phy1;
      default: begin
        rd_data = '0;
        rd_err = 1'b1;
      end
    endcase
  end

  assign wr_err = !(wr_addr == `DRS_OFF_CTL || wr_addr == `DRS_OFF_STAT ||
                    wr_addr == `DRS_OFF_PHY0 || wr_addr == `DRS_OFF_PHY1);

  // requests wait while the memory is away or the dll relocks
  assign bus_req_ready = (st_reg.seq == S_RUN) && !st_reg.ctl[`DRS_CTL_SELF_REFRESH_ACK_STATUS] &&
                         !st_reg.phy0[`DRS_PHY0_DLLRST];

  always_comb begin
    st_next = st_reg;
    st_next.mprev = mclk_s;
    if (rise && !done) begin
      st_next.cnt = 12'(st_reg.cnt - 12'h001);
    end
    if (rise && st_reg.cal_busy) begin
      if (cal_done) begin
        st_next.cal_busy = 1'b0;
      end else begin
        st_next.cal_cnt = 12'(st_reg.cal_cnt - 12'h001);
      end
    end
    // each command lasts one memory clock period
    if (rise) begin
      st_next.cmd = DRS_NOP;
    end
    // init start and cal start are self-clearing strobes
    st_next.ctl[`DRS_CTL_INIT] = 1'b0;
    st_next.phy0[`DRS_PHY0_CALSTART] = 1'b0;
    if (wr_en) begin
      if (wr_addr == `DRS_OFF_CTL) begin
        st_next.ctl = (st_reg.ctl & ~wmask) | (wr_data & wmask);
      end
      if (wr_addr == `DRS_OFF_PHY0) begin
        st_next.phy0 = (st_reg.phy0 & ~wmask) | (wr_data & wmask);
      end
      if (wr_addr == `DRS_OFF_PHY1) begin
        st_next.phy1 = (st_reg.phy1 & ~wmask) | (wr_data & wmask);
      end
    end
    // pad self-calibration against the 34 ohm resistor; none in lpddr,
    // and the memory-side driver calibration of ddr2 is not offered
    if (st_next.phy0[`DRS_PHY0_CALSTART] && mode != DRS_LPDDR &&
        !st_reg.cal_busy) begin
      st_next.cal_busy = 1'b1;
      st_next.cal_cnt = `DRS_T_PADCAL_MCLK;
    end
    unique case (st_reg.seq)
      S_OFF: begin
        if (st_next.ctl[`DRS_CTL_INIT]) begin
          // mode may arrive in the same write as the start bit
          st_next.rstn = (drs_mode_t'(st_next.ctl[`DRS_CTL_MODE]) != DRS_DDR3);
          st_next.cke = 1'b0;
          st_next.cnt = `DRS_T_RESET_MCLK;
          st_next.seq = S_RESET;
        end
      end
      S_RESET: begin
        if (rise && done) begin
          st_next.rstn = 1'b1;
          st_next.cnt = `DRS_T_CKE_MCLK;
          st_next.seq = S_CKE;
        end
      end
      S_CKE: begin
        if (rise && done) begin
          st_next.cke = 1'b1;
          if (is_ddr3) begin
            st_next.cmd = DRS_ZQCL;
            st_next.cnt = `DRS_T_ZQL_MCLK;
            st_next.seq = S_ZQ;
          end else begin
            st_next.init_done = 1'b1;
            st_next.seq = S_RUN;
          end
        end
      end
      S_ZQ: begin
        if (rise && done) begin
          st_next.init_done = 1'b1;
          st_next.srack = 1'b0;
          st_next.seq = S_RUN;
        end
      end
      S_RUN: begin
        if (st_reg.ctl[`DRS_CTL_SELF_REFRESH_ACK_STATUS] && !bus_req_valid && rise) begin
          st_next.cmd = DRS_SRE;
          st_next.cke = 1'b0;
          st_next.cnt = `DRS_T_SRE_MCLK;
          st_next.seq = S_SRE;
        end
      end
      S_SRE: begin
        if (rise && done) begin
          st_next.srack = 1'b1;
          st_next.seq = S_SR;
        end
      end
      S_SR: begin
        // exit waits until the dll is out of reset again
        if (!st_reg.ctl[`DRS_CTL_SELF_REFRESH_ACK_STATUS] && !st_reg.phy0[`DRS_PHY0_DLLRST] &&
            rise) begin
          st_next.cmd = DRS_SRX;
          st_next.cke = 1'b1;
          st_next.cnt = `DRS_T_SRX_MCLK;
          st_next.seq = S_SRX;
        end
      end
      S_SRX: begin
        if (rise && done) begin
          if (is_ddr3) begin
            st_next.cmd = DRS_ZQCL;
            st_next.cnt = `DRS_T_ZQL_MCLK;
            st_next.seq = S_ZQ;
          end else begin
            st_next.srack = 1'b0;
            st_next.seq = S_RUN;
          end
        end
      end
      default: begin
        st_next.seq = S_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // single chip: one cke, one reset, no leveling sequence at all
  assign mem_cmd = st_reg.cmd;
  assign mem_cke = st_reg.cke;
  assign mem_reset_n = st_reg.rstn;
  assign dll_reset = st_reg.phy0[`DRS_PHY0_DLLRST];
  // one source feeds both controllers; 0 selects the first generator
  assign clock_src_sel = st_reg.ctl[`DRS_CTL_CSEL];
endmodule // drs_top

// ===== pkg/drs_defines.svh
// register map, field positions and timing counts for the dram clock/reinit sequencer
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH
`define DRS_OFF_CTL 8'h00
`define DRS_OFF_STAT 8'h04
`define DRS_OFF_PHY0 8'h08
`define DRS_OFF_PHY1 8'h0c
`define DRS_CTL_SELF_REFRESH_ACK_STATUS 0
`define DRS_CTL_MODE 2:1
`define DRS_CTL_BL8 3
`define DRS_CTL_AL 6:4
`define DRS_CTL_CL 11:8
`define DRS_CTL_CWL 15:12
`define DRS_CTL_CSEL 16
`define DRS_CTL_INIT 17
`define DRS_CTL_FREQ 28:20
`define DRS_PHY0_DLLRST 0
`define DRS_PHY0_CALSTART 1
`define DRS_ST_IDLE 0
`define DRS_ST_SRACK 1
`define DRS_ST_DLLRST 2
`define DRS_ST_INITDONE 3
`define DRS_ST_CALBUSY 4
`define DRS_ST_CFGERR 5
`define DRS_ST_FREQERR 6
`define DRS_ST_CHOP 7
`define DRS_ST_RL 11:8
`define DRS_ST_WL 15:12
`define DRS_T_RESET_MCLK 12'd16
`define DRS_T_CKE_MCLK 12'd8
`define DRS_T_ZQL_MCLK 12'd512
`define DRS_T_SRE_MCLK 12'd8
`define DRS_T_SRX_MCLK 12'd16
`define DRS_T_PADCAL_MCLK 12'd300
`define DRS_FREQ_MAX_MHZ 9'd450
`define DRS_FREQ_DDR2_MIN 9'd125
`define DRS_AL_DDR2_MAX 3'd5
`define DRS_WL_LPDDR 4'h1
`define DRS_RESP_OKAY 2'h0
`define DRS_RESP_SLVERR 2'h2
`endif

// ===== pkg/drs_pkg.sv
// types shared by the sequencer and its bus slave
package drs_pkg;
  typedef enum logic [1:0] {DRS_LPDDR, DRS_DDR2, DRS_DDR3} drs_mode_t;
  typedef enum logic [1:0] {DRS_NOP, DRS_SRE, DRS_SRX, DRS_ZQCL} drs_cmd_t;
  typedef enum logic [2:0] {
    S_OFF, S_RESET, S_CKE, S_ZQ, S_RUN, S_SRE, S_SR, S_SRX
  } drs_seq_t;
  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } drs_axil_st_t;
  typedef struct packed {
    drs_seq_t seq;
    logic [31:0] ctl;
    logic [31:0] phy0;
    logic [31:0] phy1;
    logic mprev;
    logic [11:0] cnt;
    logic cal_busy;
    logic [11:0] cal_cnt;
    logic srack;
    logic init_done;
    logic cke;
    logic rstn;
    drs_cmd_t cmd;
  } drs_top_st_t;
endpackage

// ===== core/drs_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module drs_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic [1:0] ff_reg;
  logic [1:0] ff_next;
  always_comb begin
    ff_next = {ff_reg[0], async_in};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff_reg <= '0;
    end else begin
      ff_reg <= ff_next;
    end
  end
  assign sync_out = ff_reg[1];
endmodule // drs_sync

// ===== core/drs_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/100ps
`include "drs_defines.svh"
module drs_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import drs_pkg::*;
  drs_axil_st_t st_reg;
  drs_axil_st_t st_next;
  assign awready = !st_reg.aw_have;
  assign wready = !st_reg.w_have;
  assign arready = !st_reg.rvalid;
  // commit only once both halves are held and the previous response is gone
  assign wr_en = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  assign wr_addr = st_reg.awaddr;
  assign wr_data = st_reg.wdata;
  assign wr_strb = st_reg.wstrb;
  assign rd_en = arvalid && !st_reg.rvalid;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  always_comb begin
    st_next = st_reg;
    if (awvalid && !st_reg.aw_have) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = awaddr;
    end
    if (wvalid && !st_reg.w_have) begin
      st_next.w_have = 1'b1;
      st_next.wdata = wdata;
      st_next.wstrb = wstrb;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_en) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_err ? `DRS_RESP_SLVERR : `DRS_RESP_OKAY;
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_en) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data;
      st_next.rresp = rd_err ? `DRS_RESP_SLVERR : `DRS_RESP_OKAY;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // drs_axil_slave

// ===== tb/drs_top_monitor.sv
// concurrent checks on the sequencer's bus and memory-side ports
`timescale 1ns/100ps
module drs_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_req_ready,
  input wire drs_pkg::drs_cmd_t mem_cmd,
  input wire logic mem_cke,
  input wire logic mem_reset_n,
  input wire logic dll_reset
);
  import drs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cmd_new;
    $changed(mem_cmd) && mem_cmd != DRS_NOP;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_ready_cke;
    bus_req_ready |-> mem_cke && mem_reset_n;
  endproperty
  a_ready_cke: assert property (p_ready_cke) else $error("ready while memory inactive");
  property p_dll_block;
    dll_reset |-> !bus_req_ready;
  endproperty
  a_dll_block: assert property (p_dll_block) else $error("ready during dll reset");
  property p_sre_cke;
    mem_cmd == DRS_SRE |-> !mem_cke;
  endproperty
  a_sre_cke: assert property (p_sre_cke) else $error("entry with clock enable high");
  property p_rst_cke;
    !mem_reset_n |-> !mem_cke;
  endproperty
  a_rst_cke: assert property (p_rst_cke) else $error("clock enable during reset");
  property p_cmd_hold;
    s_cmd_new |=> $stable(mem_cmd) [*6];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
  property p_w_answer;
    s_wr_both |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_srx_ready;
    mem_cmd == DRS_SRX |-> !bus_req_ready;
  endproperty
  a_srx_ready: assert property (p_srx_ready) else $error("ready before exit done");
endmodule // drs_top_monitor

// ===== tb/drs_mem_model.sv
// far-side dram model: free memory clock, tracks self-refresh and zq commands
`timescale 1ns/100ps
module drs_mem_model (
  output logic memory_clock,
  input wire drs_pkg::drs_cmd_t mem_cmd,
  input wire logic mem_cke,
  input wire logic mem_reset_n,
  output logic in_sr,
  output logic [7:0] zq_count,
  output logic proto_err
);
  import drs_pkg::*;
  // one process owns every output, so each has a single driver
  initial begin
    memory_clock = 1'b0;
    in_sr = 1'b0;
    zq_count = 8'h00;
    proto_err = 1'b0;
    fork
      begin
        // offset keeps edges clear of the system clock
        #7;
        forever #100 memory_clock = ~memory_clock;
      end
      forever begin
        @(posedge memory_clock);
        case (mem_cmd)
          DRS_SRE: begin
            if (in_sr || mem_cke) proto_err <= 1'b1;
            in_sr <= 1'b1;
          end
          DRS_SRX: begin
            if (!in_sr || !mem_cke) proto_err <= 1'b1;
            in_sr <= 1'b0;
          end
          DRS_ZQCL: begin
            if (in_sr || !mem_reset_n) proto_err <= 1'b1;
            zq_count <= zq_count + 8'h01;
          end
          default: begin
            if (in_sr && mem_cke) proto_err <= 1'b1;
          end
        endcase
      end
    join
  end
endmodule // drs_mem_model

// ===== tb/drs_top_tb.sv
// self-checking bench: registers, latency decode, init and self-refresh walk
`timescale 1ns/100ps
`include "drs_defines.svh"
module drs_top_tb;
  import drs_pkg::*;
  localparam int LIM = 3000;
  // lock wait shortened; the design does not time it
  localparam int LOCK_WAIT = 90;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bus_req_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, base;
  logic memory_clock, bus_req_ready, mem_cke, mem_reset_n, dll_reset, clock_src_sel;
  logic in_sr, proto_err;
  logic [7:0] zq_count;
  drs_cmd_t mem_cmd;
  int num_errors = 0, tests_run = 0;
  drs_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .memory_clock, .bus_req_valid, .bus_req_ready, .mem_cmd, .mem_cke,
    .mem_reset_n, .dll_reset, .clock_src_sel);
  drs_mem_model i_mem (.memory_clock, .mem_cmd, .mem_cke, .mem_reset_n, .in_sr, .zq_count,
    .proto_err);
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= LIM) begin
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report();
    end
  endtask
  // sequencing runs from the bench, never from the memory it retimes
  // bready follows the address and data hand-off so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < LIM);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < LIM);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rdr(`DRS_OFF_STAT);
      n++;
    end while (rd[b] !== v && n < LIM);
    bound(n);
  endtask
  // misc is {init start, clock source, self-refresh request}
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] al,
      input logic [3:0] cl, input logic [3:0] cw, input logic b8, input logic [8:0] f,
      input logic [2:0] misc);
    return {3'h0, f, 2'h0, misc[2:1], cw, cl, 1'b0, al, b8, m, misc[0]};
  endfunction
  // exp is {wl, rl, chop, freq error, config error}
  task automatic lat(input logic [1:0] m, input logic [2:0] al, input logic [3:0] cl,
      input logic [3:0] cw, input logic b8, input logic [8:0] f, input logic [10:0] exp);
    wr(`DRS_OFF_CTL, ctl(m, al, cl, cw, b8, f, 3'h0));
    rdr(`DRS_OFF_STAT);
    chk({21'h0, rd[15:5]}, {21'h0, exp});
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`DRS_OFF_STAT);
    chk(rd, 32'h0000_1000);
    chk({30'h0, bus_req_ready, clock_src_sel}, 32'h0);
    rdr(8'h10);
    chk({rd[29:0], rsp}, {30'h0, `DRS_RESP_SLVERR});
    wr(8'h10, 32'h1);
    chk(32'(rsp), 32'(`DRS_RESP_SLVERR));
    wr(`DRS_OFF_STAT, 32'hffff_ffff);
    rdr(`DRS_OFF_STAT);
    chk(rd, 32'h0000_1000);
    wr(`DRS_OFF_PHY1, 32'h0040_0000);
    rdr(`DRS_OFF_PHY1);
    chk(rd, 32'h0040_0000);
    lat(2'h0, 3'h0, 4'h3, 4'h0, 1'b1, 9'd200, {4'h1, 4'h3, 3'b000});
    lat(2'h1, 3'h5, 4'h4, 4'h0, 1'b1, 9'd400, {4'h8, 4'h9, 3'b000});
    lat(2'h1, 3'h6, 4'h4, 4'h0, 1'b1, 9'd400, {4'h3, 4'h4, 3'b001});
    lat(2'h1, 3'h0, 4'h3, 4'h0, 1'b0, 9'd124, {4'h2, 4'h3, 3'b010});
    lat(2'h2, 3'h1, 4'h6, 4'h5, 1'b0, 9'd450, {4'ha, 4'hb, 3'b100});
    lat(2'h2, 3'h2, 4'h6, 4'h5, 1'b1, 9'd451, {4'h9, 4'ha, 3'b010});
    lat(2'h2, 3'h3, 4'h5, 4'h5, 1'b1, 9'd400, {4'h5, 4'h5, 3'b001});
    // first clock change after reset, mode left at lpddr so init must pick up ddr3
    wr(`DRS_OFF_CTL, 32'h0);
    wr(`DRS_OFF_PHY0, 32'h1);
    chk(32'(dll_reset), 32'h1);
    wr(`DRS_OFF_PHY0, 32'h0);
    chk(32'(dll_reset), 32'h0);
    repeat (LOCK_WAIT * 8) @(posedge aclk);
    base = ctl(2'h2, 3'h0, 4'h6, 4'h5, 1'b1, 9'd400, 3'b010);
    wr(`DRS_OFF_CTL, base | 32'h0002_0000);
    chk({30'h0, mem_reset_n, clock_src_sel}, 32'h1);
    poll(`DRS_ST_INITDONE, 1'b1);
    chk({29'h0, mem_reset_n, bus_req_ready, proto_err}, 32'h6);
    chk(32'(zq_count), 32'h1);
    wr(`DRS_OFF_PHY0, 32'h2);
    rdr(`DRS_OFF_STAT);
    chk(32'(rd[`DRS_ST_CALBUSY]), 32'h1);
    poll(`DRS_ST_CALBUSY, 1'b0);
    bus_req_valid <= 1'b1;
    rdr(`DRS_OFF_STAT);
    chk(32'(rd[`DRS_ST_IDLE]), 32'h0);
    wr(`DRS_OFF_CTL, base | 32'h1);
    repeat (40) @(posedge aclk);
    chk(32'(in_sr), 32'h0);
    bus_req_valid <= 1'b0;
    poll(`DRS_ST_SRACK, 1'b1);
    chk(32'(in_sr), 32'h1);
    bus_req_valid <= 1'b1;
    wr(`DRS_OFF_PHY0, 32'h1);
    chk({30'h0, dll_reset, bus_req_ready}, 32'h2);
    wr(`DRS_OFF_CTL, base);
    repeat (LOCK_WAIT * 8) @(posedge aclk);
    rdr(`DRS_OFF_STAT);
    chk({30'h0, rd[`DRS_ST_SRACK], in_sr}, 32'h3);
    wr(`DRS_OFF_PHY0, 32'h0);
    poll(`DRS_ST_SRACK, 1'b0);
    chk({30'h0, in_sr, bus_req_ready}, 32'h1);
    chk({23'h0, proto_err, zq_count}, 32'h2);
    final_report();
  end
endmodule // drs_top_tb
bind drs_top drs_top_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .bus_req_ready, .mem_cmd, .mem_cke, .mem_reset_n, .dll_reset);
